// *** hw/ebg_glue.sv ***
`default_nettype none

module ebg_glue (
    input  wire logic                    clk_i,
    input  wire logic                    reset_n_i,
    // Processor side
    input  wire logic                    cpu_req_i,
    input  wire logic                    cpu_write_i,
    input  wire logic                    cpu_burst_i,
    input  wire logic [31:0]             cpu_addr_i,
    input  wire logic [31:0]             cpu_wdata_i,
    output logic      [31:0]             cpu_rdata_o,
    output logic                         cpu_beat_o,
    output logic                         cpu_done_o,
    output logic                         cpu_cold_reset_n_o,
    output logic      [3:0]              cpu_irq_o,
    output logic      [3:0]              cpu_dma_request_o,
    input  wire logic [3:0]              cpu_dma_ack_i,
    // Board straps and sources
    input  wire logic                    board_reset_n_i,
    input  wire logic                    board_reset_req_n_i,
    input  wire logic                    slow_clock_switch_on_i,
    input  wire logic                    flash_boot_select_i,
    input  wire logic                    timer_output_zero_i,
    input  wire logic                    timer_output_one_i,
    // Expansion bus side
    output logic                         exp_bus_clock_o,
    output logic [ebg_pkg::EBG_ADDR_MSB:ebg_pkg::EBG_ADDR_LSB] exp_address_lines_o,
    input  wire logic [31:0]             exp_data_lines_i,
    output logic      [31:0]             exp_data_lines_o,
    output logic                         exp_data_lines_oe_o,
    output logic      [6:0]              exp_select_n_o,
    output logic                         exp_address_strobe_n_o,
    output logic                         exp_last_n_o,
    output logic                         exp_write_cycle_n_o,
    input  wire logic                    exp_ready_n_i,
    output logic                         exp_read_strobe_n_o,
    output logic                         exp_write_strobe_n_o,
    input  wire logic                    exp_presence_n_i,
    input  wire logic                    exp_reset_out_n_i,
    output logic                         exp_reset_in_n_o,
    output logic                         exp_slow_clock_flag_n_o,
    output logic      [1:0]              exp_timer_irq_in_n_o,
    input  wire logic [3:0]              exp_irq_request_n_i,
    input  wire logic [3:0]              exp_dma_request_n_i,
    output logic      [3:0]              exp_dma_ack_n_o
);
    import ebg_pkg::*;

    // ************************************************************
    // State of the glue
    // ************************************************************
    typedef struct packed {
        logic [EBG_SY_WIDTH-1:0] sy1;
        logic [EBG_SY_WIDTH-1:0] sy2;
        logic                    exp_bus_clock;
        ebg_fsm_t                st;
        logic [6:0]              sel_n;
        logic                    ads_n;
        logic                    last_n;
        logic                    wcyc_n;
        logic                    rd_n;
        logic                    wr_n;
        logic                    doe;
        logic                    hold;
        logic [EBG_ADDR_MSB:EBG_ADDR_LSB] addr;
        logic [31:0]             dout;
        logic [31:0]             dcap;
        logic                    rdycap;
        logic [31:0]             rdata;
        logic                    beat;
        logic                    done;
        logic [2:0]              cnt;
        logic [2:0]              last;
        logic                    cold_n;
        logic                    rstin_n;
        logic                    slow_n;
        logic [1:0]              tirq_n;
        logic [3:0]              irq;
        logic [3:0]              dreq;
        logic [3:0]              dack_n;
    } ebg_state_t;

    localparam ebg_state_t EBG_RESET = '{
        sel_n: EBG_SEL_IDLE, ads_n: 1'b1, last_n: 1'b1, wcyc_n: 1'b1, rd_n: 1'b1,
        wr_n: 1'b1, rdycap: 1'b1, slow_n: 1'b1, tirq_n: 2'h3, dack_n: EBG_LINES_IDLE,
        st: EBG_ST_IDLE, default: '0};

    ebg_state_t s_reg;
    ebg_state_t s_next;
    logic [EBG_SY_WIDTH-1:0] async_in;
    logic [6:0]              hit;
    logic                    fall;
    logic                    absent;

    // Decode a processor address into one select
    function automatic logic [6:0] ebg_decode(input logic [31:0] a, input logic boot);
        logic [31:0] u;
        logic [6:0]  h;
        u = a;
        h = '0;
        if (a[31:28] == 4'(EBG_UNCACHED_BASE[31:28] - EBG_CACHED_OFFSET[31:28])) begin
            u = a + EBG_CACHED_OFFSET;
        end
        if (u[31:28] == EBG_UNCACHED_BASE[31:28]) begin
            for (int i = 0; i < EBG_NUM_SELECTS; i++) begin
                if (i == 1) begin
                    h[i] = boot ? (u[27:EBG_WIN_LSB] == EBG_BOOT_NIBBLE)
                                : (u[27:EBG_WIN_LSB] == 4'h1);
                end else begin
                    h[i] = (u[27:EBG_WIN_LSB] == 4'(i));
                end
            end
        end
        return h;
    endfunction : ebg_decode

    // Gather the asynchronous inputs for the synchronisers
    assign async_in = {exp_dma_request_n_i, exp_irq_request_n_i, flash_boot_select_i,
                       timer_output_one_i, timer_output_zero_i, slow_clock_switch_on_i,
                       board_reset_req_n_i, board_reset_n_i, exp_reset_out_n_i,
                       exp_presence_n_i};
    assign fall   = s_reg.exp_bus_clock;
    assign absent = s_reg.sy2[EBG_SY_PRESENCE];
    assign hit    = ebg_decode(cpu_addr_i, s_reg.sy2[EBG_SY_BOOT]);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_next        = s_reg;
        s_next.sy1    = async_in;
        s_next.sy2    = s_reg.sy1;
        s_next.exp_bus_clock   = ~s_reg.exp_bus_clock;
        s_next.dcap   = exp_data_lines_i;
        s_next.rdycap = exp_ready_n_i;
        s_next.beat   = 1'b0;
        s_next.done   = 1'b0;
        // Reset, straps and side-band lines
        s_next.cold_n  = s_reg.sy2[EBG_SY_RST_OUT] & s_reg.sy2[EBG_SY_BOARD_RST];
        s_next.rstin_n = s_reg.sy2[EBG_SY_RST_REQ];
        s_next.slow_n  = ~s_reg.sy2[EBG_SY_SLOW_SW];
        s_next.tirq_n  = {s_reg.sy2[EBG_SY_TIMER1], s_reg.sy2[EBG_SY_TIMER0]};
        s_next.irq     = ~s_reg.sy2[EBG_SY_IRQ +: 4];
        s_next.dreq    = ~s_reg.sy2[EBG_SY_DREQ +: 4];
        s_next.dack_n  = ~cpu_dma_ack_i;
        // Bus cycle sequencing, bus outputs change while the bus clock falls
        case (s_reg.st)
            EBG_ST_IDLE: begin
                if (fall && cpu_req_i && !s_reg.done) begin
                    if (hit == '0) begin
                        s_next.done = 1'b1;           // Unmapped, ends at once
                    end else begin
                        s_next.sel_n  = ~hit;
                        s_next.ads_n  = 1'b0;
                        s_next.last_n = cpu_burst_i;
                        s_next.last   = cpu_burst_i ? EBG_BURST_LAST : 3'h0;
                        s_next.cnt    = 3'h0;
                        s_next.wcyc_n = ~cpu_write_i;
                        s_next.rd_n   = cpu_write_i;
                        s_next.wr_n   = ~cpu_write_i;
                        s_next.doe    = cpu_write_i;
                        s_next.dout   = cpu_wdata_i;
                        s_next.addr   = cpu_addr_i[EBG_ADDR_MSB:EBG_ADDR_LSB];
                        s_next.st     = EBG_ST_DATA;
                    end
                end
            end
            EBG_ST_DATA: begin
                if (fall && s_reg.hold) begin
                    s_next.hold = 1'b0;                // Next write word is presented now
                    s_next.dout = cpu_wdata_i;
                end else if (fall) begin
                    s_next.ads_n = 1'b1;
                    if (!s_reg.rdycap || absent) begin
                        s_next.beat  = 1'b1;
                        s_next.rdata = s_reg.dcap;
                        if (s_reg.cnt == s_reg.last) begin
                            s_next.sel_n  = EBG_SEL_IDLE;
                            s_next.last_n = 1'b1;
                            s_next.wcyc_n = 1'b1;
                            s_next.rd_n   = 1'b1;
                            s_next.wr_n   = 1'b1;
                            s_next.doe    = 1'b0;
                            s_next.done   = 1'b1;
                            s_next.st     = EBG_ST_IDLE;
                        end else begin
                            s_next.cnt    = s_reg.cnt + 3'h1;
                            // Write bursts to a fitted board wait a bus clock so stale data never lands
                            s_next.hold   = !s_reg.wcyc_n && !absent;
                            s_next.addr   = s_reg.addr + 24'h1;
                            s_next.last_n = (s_reg.cnt + 3'h1) != s_reg.last;
                        end
                    end else begin
                        s_next.dout = cpu_wdata_i;
                    end
                end
            end
            default: s_next.st = EBG_ST_IDLE;
        endcase
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_reg <= EBG_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign exp_bus_clock_o         = s_reg.exp_bus_clock;
    assign exp_address_lines_o     = s_reg.addr;
    assign exp_data_lines_o        = s_reg.dout;
    assign exp_data_lines_oe_o     = s_reg.doe;
    assign exp_select_n_o          = s_reg.sel_n;
    assign exp_address_strobe_n_o  = s_reg.ads_n;
    assign exp_last_n_o            = s_reg.last_n;
    assign exp_write_cycle_n_o     = s_reg.wcyc_n;
    assign exp_read_strobe_n_o     = s_reg.rd_n;
    assign exp_write_strobe_n_o    = s_reg.wr_n;
    assign exp_reset_in_n_o        = s_reg.rstin_n;
    assign exp_slow_clock_flag_n_o = s_reg.slow_n;
    assign exp_timer_irq_in_n_o    = s_reg.tirq_n;
    assign exp_dma_ack_n_o         = s_reg.dack_n;
    assign cpu_rdata_o             = s_reg.rdata;
    assign cpu_beat_o              = s_reg.beat;
    assign cpu_done_o              = s_reg.done;
    assign cpu_cold_reset_n_o      = s_reg.cold_n;
    assign cpu_irq_o               = s_reg.irq;
    assign cpu_dma_request_o       = s_reg.dreq;

    // ************************************************************
    // Checks
    // ************************************************************
    AST_CLK_HALF: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        exp_bus_clock_o |=> !exp_bus_clock_o ##1 exp_bus_clock_o)
        else $error("bus clock is not half rate");
    AST_READ_CAPTURE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(cpu_beat_o) && exp_write_cycle_n_o |-> cpu_rdata_o == $past(exp_data_lines_i, 2))
        else $error("read data not from captured bus value");
    AST_SEL_ON_STROBE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !exp_address_strobe_n_o |-> $onehot(~exp_select_n_o))
        else $error("address strobe without exactly one select");
    AST_ONE_SELECT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $onehot0(~exp_select_n_o))
        else $error("more than one select active");
    AST_SEL_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (s_reg.st == EBG_ST_DATA) && !s_next.done |=> $stable(exp_select_n_o))
        else $error("select changed before final ready");
    AST_SELF_READY: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (s_reg.st == EBG_ST_DATA) && absent |-> ##[1:2] cpu_beat_o)
        else $error("no self ready without board");
    AST_COLD_RESET: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !s_reg.sy2[EBG_SY_RST_OUT] || !s_reg.sy2[EBG_SY_BOARD_RST] |=> !cpu_cold_reset_n_o)
        else $error("cold reset not asserted");
    AST_SLOW_FLAG: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        s_reg.sy2[EBG_SY_SLOW_SW] |=> !exp_slow_clock_flag_n_o)
        else $error("slow clock flag wrong");
    AST_STROBES: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !(!exp_read_strobe_n_o && !exp_write_strobe_n_o))
        else $error("read and write strobes both active");
    AST_TIMER_IRQ: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        s_reg.sy2[EBG_SY_TIMER0] ##1 s_reg.sy2[EBG_SY_TIMER0] |-> exp_timer_irq_in_n_o[0])
        else $error("timer output zero not forwarded");
    AST_DMA_ACK: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        cpu_dma_ack_i[0] |=> !exp_dma_ack_n_o[0])
        else $error("dma acknowledge not forwarded");

endmodule : ebg_glue
`default_nettype wire

// *** hw/ebg_pkg.sv ***
`default_nettype none
package ebg_pkg;

    // ************************************************************
    // Address map of the expansion selects
    // ************************************************************
    localparam logic [31:0] EBG_UNCACHED_BASE = 32'hB000_0000; // Select 0 window start
    localparam logic [31:0] EBG_CACHED_OFFSET = 32'h2000_0000; // Cached alias lies below
    localparam logic [3:0]  EBG_BOOT_NIBBLE   = 4'hF;          // Select 1 window when boot on
    localparam int          EBG_NUM_SELECTS   = 7;
    localparam int          EBG_WIN_LSB       = 24;            // 16 MB windows
    localparam int          EBG_ADDR_MSB      = 25;            // Highest driven address line
    localparam int          EBG_ADDR_LSB      = 2;

    // ************************************************************
    // Bus timing and reset values
    // ************************************************************
    localparam logic [2:0]  EBG_BURST_LAST    = 3'h3;          // Burst of four beats
    localparam logic [6:0]  EBG_SEL_IDLE      = 7'h7F;
    localparam logic [3:0]  EBG_LINES_IDLE    = 4'hF;

    // ************************************************************
    // Positions in the vector of asynchronous inputs
    // ************************************************************
    localparam int EBG_SY_PRESENCE  = 0;
    localparam int EBG_SY_RST_OUT   = 1;
    localparam int EBG_SY_BOARD_RST = 2;
    localparam int EBG_SY_RST_REQ   = 3;
    localparam int EBG_SY_SLOW_SW   = 4;
    localparam int EBG_SY_TIMER0    = 5;
    localparam int EBG_SY_TIMER1    = 6;
    localparam int EBG_SY_BOOT      = 7;
    localparam int EBG_SY_IRQ       = 8;   // Four lines
    localparam int EBG_SY_DREQ      = 12;  // Four lines
    localparam int EBG_SY_WIDTH     = 16;

    typedef enum logic [0:0] {
        EBG_ST_IDLE,
        EBG_ST_DATA
    } ebg_fsm_t;

endpackage : ebg_pkg
`default_nettype wire

// *** bench/ebg_board_model.sv ***
`default_nettype none
// ************************************************************
// Expansion board: word memory answering selects and strobes
// ************************************************************
module ebg_board_model (
    input  wire logic        clk_i,
    input  wire logic        present_i,
    input  wire logic        slow_i,
    input  wire logic [6:0]  sel_n_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    input  wire logic        oe_i,
    input  wire logic [25:2] addr_i,
    input  wire logic [31:0] wdata_i,
    output logic      [31:0] rdata_o,
    output logic             ready_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [64];
    logic [2:0]  gap;
    logic        junk;
    logic        act;

    // Fill memory with a known pattern
    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = {8'hC3, 18'h0, i[5:0]};
        end
        gap = 3'h0;
        junk = 1'b0;
        ready_n_o = 1'b1;
    end

    // Board answers only when fitted, selected and strobed
    assign act = present_i && (sel_n_i != 7'h7F) && !(rd_n_i && wr_n_i);
    // Released data lines show a value that changes every cycle
    assign rdata_o = (act && !rd_n_i) ? mem[addr_i[7:2]] : {32{junk}};

    // Ready at once, or one cycle in five when slow; writes land on ready
    always @(posedge clk_i) begin
        gap <= (gap == 3'h4) ? 3'h0 : gap + 3'h1;
        junk <= ~junk;
        ready_n_o <= !(act && (!slow_i || gap == 3'h4));
        if (act && !ready_n_o && !wr_n_i && oe_i) begin
            mem[addr_i[7:2]] <= wdata_i;
        end
    end
endmodule : ebg_board_model
`default_nettype wire

// *** bench/tb_top.sv ***
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ebg_pkg::*;
    logic clk_i = 1'b0, reset_n_i = 1'b0, cpu_req_i = 1'b0, cpu_write_i = 1'b0;
    logic cpu_burst_i = 1'b0, board_reset_n_i = 1'b1, board_reset_req_n_i = 1'b1;
    logic slow_clock_switch_on_i = 1'b0, flash_boot_select_i = 1'b0, slow_mode = 1'b0;
    logic timer_output_zero_i = 1'b0, timer_output_one_i = 1'b0, exp_presence_n_i = 1'b0;
    logic exp_reset_out_n_i = 1'b1, exp_ready_n_i;
    logic [31:0] cpu_addr_i = 32'h0, cpu_wdata_i = 32'h0, exp_data_lines_i, r, a;
    logic [3:0]  cpu_dma_ack_i = 4'h0, exp_irq_request_n_i = 4'hF, exp_dma_request_n_i = 4'hF;
    logic [31:0] cpu_rdata_o, exp_data_lines_o, addr_seen, wd [4], sh [64];
    logic [3:0]  cpu_irq_o, cpu_dma_request_o, exp_dma_ack_n_o;
    logic [6:0]  exp_select_n_o, sel_seen;
    logic [5:0]  ctl_seen;
    logic [1:0]  exp_timer_irq_in_n_o;
    logic [25:2] exp_address_lines_o;
    logic cpu_beat_o, cpu_done_o, cpu_cold_reset_n_o, exp_bus_clock_o, exp_data_lines_oe_o;
    logic exp_address_strobe_n_o, exp_last_n_o, exp_write_cycle_n_o, exp_read_strobe_n_o;
    logic exp_write_strobe_n_o, exp_reset_in_n_o, exp_slow_clock_flag_n_o, got_addr, b;
    logic [31:0] exp_q [$];
    int num_errors = 0, n_checks = 0, seed = 24;

    always #10 clk_i = ~clk_i;

    ebg_glue dut_u (.clk_i, .reset_n_i, .cpu_req_i, .cpu_write_i, .cpu_burst_i, .cpu_addr_i,
        .cpu_wdata_i, .cpu_rdata_o, .cpu_beat_o, .cpu_done_o, .cpu_cold_reset_n_o, .cpu_irq_o,
        .cpu_dma_request_o, .cpu_dma_ack_i, .board_reset_n_i, .board_reset_req_n_i,
        .slow_clock_switch_on_i, .flash_boot_select_i, .timer_output_zero_i,
        .timer_output_one_i, .exp_bus_clock_o, .exp_address_lines_o, .exp_data_lines_i,
        .exp_data_lines_o, .exp_data_lines_oe_o, .exp_select_n_o, .exp_address_strobe_n_o,
        .exp_last_n_o, .exp_write_cycle_n_o, .exp_ready_n_i, .exp_read_strobe_n_o,
        .exp_write_strobe_n_o, .exp_presence_n_i, .exp_reset_out_n_i, .exp_reset_in_n_o,
        .exp_slow_clock_flag_n_o, .exp_timer_irq_in_n_o, .exp_irq_request_n_i,
        .exp_dma_request_n_i, .exp_dma_ack_n_o);

    ebg_board_model brd_u (.clk_i, .present_i(!exp_presence_n_i), .slow_i(slow_mode),
        .sel_n_i(exp_select_n_o), .rd_n_i(exp_read_strobe_n_o), .wr_n_i(exp_write_strobe_n_o),
        .oe_i(exp_data_lines_oe_o), .addr_i(exp_address_lines_o), .wdata_i(exp_data_lines_o),
        .rdata_o(exp_data_lines_i), .ready_n_o(exp_ready_n_i));

    // ************************************************************
    // Shared checking, reporting and bus tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize

    // One processor request; expectations queued before it starts
    task automatic bus_op(input logic wr, input logic bst, input logic [31:0] ad, input int nb,
                          input logic [6:0] sel, input logic dchk);
        int beats;
        logic [5:0] ix;
        beats = 0;
        ix = ad[7:2];
        @(posedge clk_i);
        sel_seen = 7'h00;
        got_addr = 1'b0;
        for (int k = 0; k < nb; k++) begin
            wd[k] = $random(seed);
            if (wr) sh[ix + k[5:0]] = wd[k];
            else if (dchk) exp_q.push_back(sh[ix + k[5:0]]);
        end
        cpu_write_i <= wr;
        cpu_burst_i <= bst;
        cpu_addr_i <= ad;
        cpu_wdata_i <= wd[0];
        cpu_req_i <= 1'b1;
        for (int k = 0; k < 200; k++) begin
            @(posedge clk_i);
            if (cpu_beat_o === 1'b1) beats++;
            if (cpu_beat_o === 1'b1 && beats < 4) cpu_wdata_i <= wd[beats];
            if (cpu_done_o === 1'b1) break;
        end
        cpu_req_i <= 1'b0;
        chk(beats, nb, "beat count");
        chk(sel_seen, sel, "selects seen");
        if (nb > 0) chk(addr_seen, ad[25:2], "first address");
        if (nb > 0) chk(ctl_seen, {wr, !wr, !wr, 1'b0, bst, wr}, "bus controls");
    endtask : bus_op

    // Watch selects and address during requests, compare read words at each beat
    always @(posedge clk_i) begin
        if (reset_n_i && cpu_req_i) sel_seen |= ~exp_select_n_o;
        if (!got_addr && cpu_req_i && exp_select_n_o != 7'h7F) begin
            got_addr = 1'b1;
            addr_seen = exp_address_lines_o;
            ctl_seen = {exp_read_strobe_n_o, exp_write_strobe_n_o, exp_write_cycle_n_o,
                        exp_address_strobe_n_o, exp_last_n_o, exp_data_lines_oe_o};
        end
        if (cpu_beat_o === 1'b1 && exp_q.size() > 0) begin
            chk(cpu_rdata_o, exp_q.pop_front(), "word");
        end
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        for (int i = 0; i < 64; i++) sh[i] = {8'hC3, 18'h0, i[5:0]};
        repeat (12) @(posedge clk_i);
        chk(exp_select_n_o, 7'h7F, "selects in reset");
        chk(exp_dma_ack_n_o, 4'hF, "dma ack in reset");
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        for (int i = 0; i < 6; i++) begin
            b = exp_bus_clock_o;
            @(posedge clk_i);
            chk(exp_bus_clock_o, !b, "bus clock");
        end
        $display("test bus clock done at %0t", $time);
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            board_reset_n_i <= r[0];
            exp_reset_out_n_i <= r[1];
            board_reset_req_n_i <= r[2];
            slow_clock_switch_on_i <= r[3];
            timer_output_zero_i <= r[4];
            timer_output_one_i <= r[5];
            exp_irq_request_n_i <= r[9:6];
            exp_dma_request_n_i <= r[13:10];
            cpu_dma_ack_i <= r[17:14];
            repeat (4) @(posedge clk_i);
            chk(cpu_cold_reset_n_o, r[0] & r[1], "cold reset");
            chk(exp_reset_in_n_o, r[2], "bus reset in");
            chk(exp_slow_clock_flag_n_o, !r[3], "slow flag");
            chk(exp_timer_irq_in_n_o, r[5:4], "timer irq");
            chk(cpu_irq_o, 4'(~r[9:6]), "irq");
            chk(cpu_dma_request_o, 4'(~r[13:10]), "dma request");
            chk(exp_dma_ack_n_o, 4'(~r[17:14]), "dma ack");
        end
        board_reset_n_i <= 1'b1;
        exp_reset_out_n_i <= 1'b1;
        $display("test side lines done at %0t", $time);
        for (int i = 0; i < 14; i++) begin
            a = {i[0] ? 4'h9 : 4'hB, 1'b0, i[3:1], 18'h0, i[3:0], 2'h0};
            bus_op(1'b0, 1'b0, a, 1, 7'h01 << i[3:1], 1'b1);
        end
        bus_op(1'b0, 1'b0, 32'hB6FF_FFFC, 1, 7'h40, 1'b1);
        bus_op(1'b0, 1'b0, 32'hB700_0000, 0, 7'h00, 1'b0);
        bus_op(1'b0, 1'b0, 32'hBF00_0000, 0, 7'h00, 1'b0);
        flash_boot_select_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        bus_op(1'b0, 1'b0, 32'hBF00_0040, 1, 7'h02, 1'b1);
        bus_op(1'b0, 1'b0, 32'h9FFF_FFFC, 1, 7'h02, 1'b1);
        bus_op(1'b0, 1'b0, 32'hB100_0000, 0, 7'h00, 1'b0);
        flash_boot_select_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        $display("test decode done at %0t", $time);
        bus_op(1'b1, 1'b0, 32'hB400_0008, 1, 7'h10, 1'b0);
        bus_op(1'b0, 1'b0, 32'hB400_0008, 1, 7'h10, 1'b1);
        slow_mode <= 1'b1;
        bus_op(1'b1, 1'b1, 32'hB300_0010, 4, 7'h08, 1'b0);
        bus_op(1'b0, 1'b1, 32'hB300_0010, 4, 7'h08, 1'b1);
        slow_mode <= 1'b0;
        bus_op(1'b1, 1'b1, 32'h9000_0020, 4, 7'h01, 1'b0);
        bus_op(1'b0, 1'b1, 32'hB000_0020, 4, 7'h01, 1'b1);
        $display("test transfers done at %0t", $time);
        exp_presence_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        bus_op(1'b0, 1'b0, 32'hB200_0000, 1, 7'h04, 1'b0);
        bus_op(1'b1, 1'b1, 32'hB200_0030, 4, 7'h04, 1'b0);
        $display("test no board done at %0t", $time);
        summarize();
    end

    // Watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire
